// ---- rtl/cpuodw_core.sv ----
// Purpose: Operand assembly, flag update, transfer and wait control
// Assumes: Operand bytes arrive one per cycle with op_byte_valid
// Notes: Interrupt request pin is synchronised here
// What this block does
// - The wait instruction spends 12 cycles from its opcode fetch saving registers.
// - The wait state lasts n whole cycles and ends on a recognised interrupt or on reset.
// - Two more cycles fetch the vector, so the instruction takes 14 + n cycles.
// - An extended address is two bytes, high byte first.
// - A 16-bit immediate is two bytes, high byte first, joined into one value.
// - An 8-bit immediate is the single byte after the opcode, used as data.
// - A mask byte selects the memory bits changed; cleared bits leave them alone.
// - Result-dependent flags follow the outcome; unchanged flags keep their value.
// - A transfer into the flag register may clear the clear-only bit but never set it.
// - Subtraction uses two's complement at the operand width.
`timescale 1ns/100ps
module cpuodw_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Instruction stream
    input wire logic op_start,
    input wire logic op_page1,
    input wire logic [7:0] op_code,
    input wire cpuodw_pkg::cpuodw_mode_type op_mode,
    input wire logic op_byte_valid,
    input wire logic [7:0] op_byte,
    input wire logic [15:0] pc_next,
    // Memory data and transfer source
    input wire logic [7:0] mem_data,
    input wire logic [7:0] mem_target,
    input wire logic [7:0] flags_src,
    // Interrupt pin
    input wire logic irq_pin,
    // Results
    output logic [15:0] eff_addr,
    output logic [15:0] imm_value,
    output logic [7:0] masked_data,
    output logic operand_done,
    output logic [7:0] flag_register,
    output logic [15:0] acc_d,
    output logic [15:0] index_x,
    output logic [15:0] index_y,
    output logic [15:0] stack_pointer,
    output logic [7:0] diff_out,
    output logic wait_busy,
    output logic wait_idle,
    output logic wait_vector,
    output logic wait_done,
    output logic [31:0] wait_total
);
    cpuodw_wait_if wif ();
    logic irq_s1_q, irq_s2_q;
    logic [7:0] hi_q;
    logic have_hi_q;
    logic [15:0] x_q, y_q, sp_q, d_q;
    logic [7:0] ccr_q;
    logic [15:0] base;

    // ************************
    // Interrupt synchroniser and wait sequencer
    // ************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
        end else begin
            irq_s1_q <= irq_pin;
            irq_s2_q <= irq_s1_q;
        end
    end
    assign wif.start = op_start && !op_page1 && (op_code == cpuodw_pkg::OP_WAIT);
    assign wif.irq = irq_s2_q;
    cpuodw_wait_seq u_seq (
        .sys_clk(sys_clk),
        .reset(reset),
        .wif(wif)
    );
    assign wait_busy = wif.busy;
    assign wait_idle = wif.idle;
    assign wait_vector = wif.vector_fetch;
    assign wait_done = wif.done;
    assign wait_total = wif.total_cycles;

    // ************************
    // Operand assembly
    // ************************
    assign base = op_page1 ? y_q : x_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hi_q <= 8'h00;
            have_hi_q <= 1'b0;
            eff_addr <= 16'h0000;
            imm_value <= 16'h0000;
            masked_data <= 8'h00;
            operand_done <= 1'b0;
        end else begin
            operand_done <= 1'b0;
            if (op_start) begin
                have_hi_q <= 1'b0;
            end else if (op_byte_valid) begin
                case (op_mode)
                    cpuodw_pkg::MODE_DIR: begin
                        eff_addr <= {cpuodw_pkg::DIRECT_PAGE, op_byte};
                        operand_done <= 1'b1;
                    end
                    cpuodw_pkg::MODE_IDX: begin
                        eff_addr <= base + {8'h00, op_byte};
                        operand_done <= 1'b1;
                    end
                    cpuodw_pkg::MODE_REL: begin
                        // Sign extend so backward branches wrap correctly
                        eff_addr <= pc_next + {{8{op_byte[7]}}, op_byte};
                        operand_done <= 1'b1;
                    end
                    cpuodw_pkg::MODE_EXT, cpuodw_pkg::MODE_IMM16: begin
                        if (!have_hi_q) begin
                            hi_q <= op_byte;
                            have_hi_q <= 1'b1;
                        end else begin
                            have_hi_q <= 1'b0;
                            operand_done <= 1'b1;
                            if (op_mode == cpuodw_pkg::MODE_EXT) begin
                                eff_addr <= {hi_q, op_byte};
                            end else begin
                                imm_value <= {hi_q, op_byte};
                            end
                        end
                    end
                    cpuodw_pkg::MODE_IMM8: begin
                        imm_value <= {8'h00, op_byte};
                        operand_done <= 1'b1;
                    end
                    cpuodw_pkg::MODE_MASK: begin
                        // Set bits of the mask force the target bit to one, others keep the target
                        masked_data <= (mem_target & ~op_byte) | op_byte;
                        operand_done <= 1'b1;
                    end
                    default: operand_done <= 1'b0;
                endcase
            end
        end
    end

    // ************************
    // Register transfers and flags
    // ************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            x_q <= 16'h0000;
            y_q <= 16'h0000;
            sp_q <= 16'h0000;
            d_q <= 16'h0000;
            ccr_q <= cpuodw_pkg::FLAG_RESET;
            diff_out <= 8'h00;
        end else if (op_start) begin
            case (op_code)
                cpuodw_pkg::OP_TEST_EXT, cpuodw_pkg::OP_TEST_IDX,
                cpuodw_pkg::OP_TEST_A, cpuodw_pkg::OP_TEST_B: begin
                    // Other flag bits are left as they were
                    diff_out <= mem_data - 8'h00;
                    ccr_q[cpuodw_pkg::FLAG_N] <= mem_data[7];
                    ccr_q[cpuodw_pkg::FLAG_Z] <= (mem_data == 8'h00);
                    ccr_q[cpuodw_pkg::FLAG_V] <= 1'b0;
                    ccr_q[cpuodw_pkg::FLAG_C] <= 1'b0;
                end
                cpuodw_pkg::OP_SP_TO_IDX: begin
                    if (op_page1) y_q <= sp_q + 16'h0001;
                    else x_q <= sp_q + 16'h0001;
                end
                cpuodw_pkg::OP_IDX_TO_SP: begin
                    sp_q <= base - 16'h0001;
                end
                cpuodw_pkg::OP_SWAP_D: begin
                    d_q <= base;
                    if (op_page1) y_q <= d_q;
                    else x_q <= d_q;
                end
                cpuodw_pkg::OP_TO_FLAGS: begin
                    // X bit may only fall
                    ccr_q <= {flags_src[7], ccr_q[cpuodw_pkg::FLAG_X] & flags_src[6],
                        flags_src[5:0]};
                end
                default: ccr_q <= ccr_q;
            endcase
        end
    end

    assign flag_register = ccr_q;
    assign acc_d = d_q;
    assign index_x = x_q;
    assign index_y = y_q;
    assign stack_pointer = sp_q;

    a_x_never_sets: assert property (@(posedge sys_clk) disable iff (reset)
        (op_start && op_code == cpuodw_pkg::OP_TO_FLAGS && !ccr_q[cpuodw_pkg::FLAG_X])
        |=> !ccr_q[cpuodw_pkg::FLAG_X])
        else $error("clear-only flag became set");
    a_test_flags: assert property (@(posedge sys_clk) disable iff (reset)
        (op_start && op_code == cpuodw_pkg::OP_TEST_A)
        |=> !ccr_q[cpuodw_pkg::FLAG_V] && !ccr_q[cpuodw_pkg::FLAG_C]
            && ccr_q[cpuodw_pkg::FLAG_Z] == ($past(mem_data) == 8'h00))
        else $error("test flags wrong");
    a_swap_keeps: assert property (@(posedge sys_clk) disable iff (reset)
        (op_start && op_code == cpuodw_pkg::OP_SWAP_D && !op_page1)
        |=> d_q == $past(x_q) && x_q == $past(d_q) && $stable(ccr_q))
        else $error("exchange wrong");
    a_sp_plus_one: assert property (@(posedge sys_clk) disable iff (reset)
        (op_start && op_code == cpuodw_pkg::OP_SP_TO_IDX && !op_page1)
        |=> x_q == $past(sp_q) + 16'h0001)
        else $error("stack to index wrong");
    a_direct_page: assert property (@(posedge sys_clk) disable iff (reset)
        (!op_start && op_byte_valid && op_mode == cpuodw_pkg::MODE_DIR)
        |=> eff_addr[15:8] == 8'h00 && operand_done)
        else $error("direct page not zero");
endmodule

// ---- rtl/cpuodw_pkg.sv ----
// Purpose: Shared constants for the operand decode and wait sequencer
// Assumes: One bus cycle per sys_clk edge
// Notes: Opcodes are the page-0 and page-1 codes the block decodes
package cpuodw_pkg;
    // ************************
    // Wait sequence timing
    // ************************
    localparam int unsigned WAIT_SAVE_CYCLES = 12;
    localparam int unsigned WAIT_VECTOR_CYCLES = 2;
    localparam int unsigned WAIT_BASE_CYCLES = WAIT_SAVE_CYCLES + WAIT_VECTOR_CYCLES;
    // ************************
    // Opcodes
    // ************************
    localparam logic [7:0] OP_PAGE1 = 8'h18;
    localparam logic [7:0] OP_WAIT = 8'h3E;
    localparam logic [7:0] OP_TEST_EXT = 8'h7D;
    localparam logic [7:0] OP_TEST_IDX = 8'h6D;
    localparam logic [7:0] OP_TEST_A = 8'h4D;
    localparam logic [7:0] OP_TEST_B = 8'h5D;
    localparam logic [7:0] OP_SP_TO_IDX = 8'h30;
    localparam logic [7:0] OP_IDX_TO_SP = 8'h35;
    localparam logic [7:0] OP_SWAP_D = 8'h8F;
    localparam logic [7:0] OP_TO_FLAGS = 8'h06;
    // ************************
    // Flag bit positions
    // ************************
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_V = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_X = 6;
    localparam logic [7:0] FLAG_RESET = 8'hD0;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;
    // ************************
    // Operand modes
    // ************************
    typedef enum logic [2:0] {
        MODE_INH, MODE_IMM8, MODE_IMM16, MODE_DIR, MODE_EXT, MODE_IDX, MODE_REL, MODE_MASK
    } cpuodw_mode_type;
endpackage

// ---- rtl/cpuodw_wait_if.sv ----
// Purpose: Carries the wait request and status between main file and sequencer
// Assumes: Single sys_clk domain
// Notes: None
`timescale 1ns/100ps
interface cpuodw_wait_if;
    logic start;
    logic irq;
    logic busy;
    logic idle;
    logic vector_fetch;
    logic done;
    logic [31:0] total_cycles;
    modport main (output start, output irq, input busy, input idle, input vector_fetch,
        input done, input total_cycles);
    modport seq (input start, input irq, output busy, output idle, output vector_fetch,
        output done, output total_cycles);
endinterface

// ---- rtl/cpuodw_wait_seq.sv ----
// Purpose: Wait-for-interrupt cycle sequencer
// Assumes: irq already synchronised
// Notes: Counts save, idle and vector cycles
`timescale 1ns/100ps
module cpuodw_wait_seq (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Request and status
    cpuodw_wait_if.seq wif
);
    typedef enum logic [1:0] {ST_OFF, ST_SAVE, ST_IDLE, ST_VEC} cpuodw_wstate_type;
    cpuodw_wstate_type state_q;
    logic [3:0] cnt_q;
    logic [31:0] total_q;
    logic [3:0] save_run_q;

    // ************************
    // Sequence
    // ************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_OFF;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (wif.start) begin
                        state_q <= ST_SAVE;
                        cnt_q <= 4'h1;
                    end
                end
                ST_SAVE: begin
                    // Opcode fetch cycle is the first of the save cycles
                    if (cnt_q == 4'(cpuodw_pkg::WAIT_SAVE_CYCLES - 1)) begin
                        state_q <= ST_IDLE;
                        cnt_q <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_IDLE: begin
                    // Only a recognised interrupt ends idle; reset is the other exit
                    if (wif.irq) begin
                        state_q <= ST_VEC;
                        cnt_q <= 4'h0;
                    end
                end
                ST_VEC: begin
                    if (cnt_q == 4'(cpuodw_pkg::WAIT_VECTOR_CYCLES - 1)) begin
                        state_q <= ST_OFF;
                    end
                    cnt_q <= cnt_q + 4'h1;
                end
                default: state_q <= ST_OFF;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            total_q <= 32'h0;
        end else if (state_q == ST_OFF && wif.start) begin
            total_q <= 32'h1;
        end else if (state_q != ST_OFF) begin
            total_q <= total_q + 32'h1;
        end
    end

    assign wif.busy = (state_q != ST_OFF);
    assign wif.idle = (state_q == ST_IDLE);
    assign wif.vector_fetch = (state_q == ST_VEC);
    assign wif.done = (state_q == ST_VEC) &&
        (cnt_q == 4'(cpuodw_pkg::WAIT_VECTOR_CYCLES - 1));
    assign wif.total_cycles = total_q;

    // Length of the current save run, read only by the assertions
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            save_run_q <= 4'h0;
        end else if (state_q == ST_SAVE) begin
            save_run_q <= save_run_q + 4'h1;
        end else begin
            save_run_q <= 4'h0;
        end
    end

    sequence s_vec_two;
        (state_q == ST_VEC) [*2] ##1 (state_q == ST_OFF);
    endsequence

    a_save_then_idle: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_OFF && wif.start) |=> (state_q == ST_SAVE) ##11 wif.idle)
        else $error("save phase not twelve cycles");
    a_save_run_len: assert property (@(posedge sys_clk) disable iff (reset)
        (wif.idle && save_run_q != 4'h0)
        |-> save_run_q == 4'(cpuodw_pkg::WAIT_SAVE_CYCLES - 1))
        else $error("save run length wrong");
    a_idle_holds: assert property (@(posedge sys_clk) disable iff (reset)
        (wif.idle && !wif.irq) |=> wif.idle)
        else $error("idle left without interrupt");
    a_vector_two: assert property (@(posedge sys_clk) disable iff (reset)
        (wif.idle && wif.irq) |=> s_vec_two)
        else $error("vector fetch not two cycles");
endmodule

// ---- test/cpuodw_prog_mem.sv ----
// Purpose: Program memory model feeding operand bytes to the core
// Assumes: One byte per cycle, or one idle cycle between bytes when slow
// Notes: Between bytes the data lines flip, so stale data is never seen
`timescale 1ns/100ps
module cpuodw_prog_mem (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Fetch request from the bench
    input wire logic req,
    input wire logic slow,
    input wire logic [1:0] count,
    input wire logic [15:0] word,
    // Byte stream to the core
    output logic op_byte_valid,
    output logic [7:0] op_byte
);
    // ************************
    // Byte sender
    // ************************
    logic [1:0] left_q;
    logic [15:0] word_q;
    logic slow_q;
    logic gap_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            left_q <= 2'h0;
            word_q <= 16'h0000;
            slow_q <= 1'b0;
            gap_q <= 1'b0;
            op_byte_valid <= 1'b0;
            op_byte <= 8'h00;
        end else if (req) begin
            left_q <= count;
            word_q <= word;
            slow_q <= slow;
            gap_q <= 1'b0;
            op_byte_valid <= 1'b0;
            op_byte <= ~op_byte;
        end else if (left_q != 2'h0 && !(slow_q && gap_q)) begin
            // High byte goes out first
            op_byte_valid <= 1'b1;
            op_byte <= (left_q == 2'h2) ? word_q[15:8] : word_q[7:0];
            left_q <= left_q - 2'h1;
            gap_q <= 1'b1;
        end else begin
            op_byte_valid <= 1'b0;
            op_byte <= ~op_byte;
            gap_q <= 1'b0;
        end
    end
endmodule

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the operand decode and wait core
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes: Results are sampled 1 ns after the edge so they have settled
`timescale 1ns/100ps
module testbench;
    logic sys_clk, reset, op_start, op_page1, irq_pin, req, slow;
    logic op_byte_valid, operand_done, wait_busy, wait_idle, wait_vector, wait_done;
    logic [7:0] op_code, op_byte, mem_data, mem_target, flags_src, masked_data;
    logic [7:0] flag_register, diff_out;
    logic [15:0] pc_next, word, eff_addr, imm_value, acc_d, index_x, index_y, stack_pointer;
    logic [1:0] count;
    logic [31:0] wait_total;
    cpuodw_pkg::cpuodw_mode_type op_mode;
    int errors, n_tests;

    cpuodw_core dut (.sys_clk(sys_clk), .reset(reset), .op_start(op_start),
        .op_page1(op_page1), .op_code(op_code), .op_mode(op_mode),
        .op_byte_valid(op_byte_valid), .op_byte(op_byte), .pc_next(pc_next),
        .mem_data(mem_data), .mem_target(mem_target), .flags_src(flags_src),
        .irq_pin(irq_pin), .eff_addr(eff_addr), .imm_value(imm_value),
        .masked_data(masked_data), .operand_done(operand_done),
        .flag_register(flag_register), .acc_d(acc_d), .index_x(index_x),
        .index_y(index_y), .stack_pointer(stack_pointer), .diff_out(diff_out),
        .wait_busy(wait_busy), .wait_idle(wait_idle), .wait_vector(wait_vector),
        .wait_done(wait_done), .wait_total(wait_total));
    cpuodw_prog_mem mem (.sys_clk(sys_clk), .reset(reset), .req(req), .slow(slow),
        .count(count), .word(word), .op_byte_valid(op_byte_valid), .op_byte(op_byte));

    // ************************
    // Helpers
    // ************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("tests=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic op(input logic [7:0] code, input logic page1);
        @(posedge sys_clk);
        op_start <= 1'b1;
        op_code <= code;
        op_page1 <= page1;
        op_mode <= cpuodw_pkg::MODE_INH;
        @(posedge sys_clk);
        op_start <= 1'b0;
        op_page1 <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    // Opcode cycle, then the partner streams the operand bytes
    task automatic fetch(input cpuodw_pkg::cpuodw_mode_type m, input logic [15:0] w,
        input logic [1:0] c, input logic s);
        int i;
        @(posedge sys_clk);
        op_start <= 1'b1;
        op_code <= 8'h01;
        op_mode <= m;
        req <= 1'b1;
        word <= w;
        count <= c;
        slow <= s;
        @(posedge sys_clk);
        op_start <= 1'b0;
        req <= 1'b0;
        for (i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            #1;
            if (operand_done === 1'b1)
                break;
        end
        if (i == 10)
            check(operand_done, 1'b1);
    endtask

    // ************************
    // Scenarios
    // ************************
    task automatic test_reset;
        check(flag_register, cpuodw_pkg::FLAG_RESET);
        check({acc_d, stack_pointer}, 32'h0);
        check({index_x, index_y}, 32'h0);
        check(wait_busy, 1'b0);
        $display("test reset done");
    endtask
    task automatic test_transfer;
        op(cpuodw_pkg::OP_SP_TO_IDX, 1'b0);
        check(index_x, 16'h0001);
        op(cpuodw_pkg::OP_SWAP_D, 1'b0);
        check({acc_d, index_x}, 32'h0001_0000);
        op(cpuodw_pkg::OP_IDX_TO_SP, 1'b0);
        check(stack_pointer, 16'hFFFF);
        op(cpuodw_pkg::OP_SWAP_D, 1'b1);
        check({acc_d, index_y}, 32'h0000_0001);
        op(cpuodw_pkg::OP_IDX_TO_SP, 1'b1);
        check(stack_pointer, 16'h0000);
        op(cpuodw_pkg::OP_SP_TO_IDX, 1'b0);
        check(index_x, 16'h0001);
        check(flag_register, cpuodw_pkg::FLAG_RESET);
        $display("test transfer done");
    endtask
    task automatic test_operands;
        fetch(cpuodw_pkg::MODE_DIR, 16'h3C5A, 2'h1, 1'b0);
        check(eff_addr, 16'h005A);
        fetch(cpuodw_pkg::MODE_IDX, 16'h00FF, 2'h1, 1'b1);
        check(eff_addr, 16'h0100);
        pc_next <= 16'h1000;
        fetch(cpuodw_pkg::MODE_REL, 16'h0080, 2'h1, 1'b0);
        check(eff_addr, 16'h0F80);
        fetch(cpuodw_pkg::MODE_REL, 16'h007F, 2'h1, 1'b0);
        check(eff_addr, 16'h107F);
        fetch(cpuodw_pkg::MODE_EXT, 16'h1234, 2'h2, 1'b1);
        check(eff_addr, 16'h1234);
        fetch(cpuodw_pkg::MODE_IMM16, 16'hABCD, 2'h2, 1'b0);
        check(imm_value, 16'hABCD);
        fetch(cpuodw_pkg::MODE_IMM8, 16'h00C3, 2'h1, 1'b0);
        check(imm_value, 16'h00C3);
        mem_target <= 8'hA5;
        fetch(cpuodw_pkg::MODE_MASK, 16'h000F, 2'h1, 1'b0);
        check(masked_data, 8'hAF);
        $display("test operands done");
    endtask
    task automatic test_flags;
        mem_data <= 8'h80;
        op(cpuodw_pkg::OP_TEST_EXT, 1'b0);
        check(flag_register, 8'hD8);
        mem_data <= 8'h00;
        op(cpuodw_pkg::OP_TEST_EXT, 1'b0);
        check(flag_register, 8'hD4);
        flags_src <= 8'hFF;
        op(cpuodw_pkg::OP_TO_FLAGS, 1'b0);
        mem_data <= 8'h01;
        op(cpuodw_pkg::OP_TEST_EXT, 1'b0);
        check(flag_register, 8'hF0);
        check(diff_out, 8'h01);
        mem_data <= 8'h00;
        op(cpuodw_pkg::OP_TEST_A, 1'b0);
        check(flag_register, 8'hF4);
        flags_src <= 8'h00;
        op(cpuodw_pkg::OP_TO_FLAGS, 1'b0);
        check(flag_register, 8'h00);
        flags_src <= 8'hFF;
        op(cpuodw_pkg::OP_TO_FLAGS, 1'b0);
        check(flag_register, 8'hBF);
        $display("test flags done");
    endtask
    task automatic test_wait;
        int i, save, idle_n, vec;
        save = 0;
        idle_n = 0;
        vec = 0;
        @(posedge sys_clk);
        op_start <= 1'b1;
        op_code <= cpuodw_pkg::OP_WAIT;
        @(posedge sys_clk);
        op_start <= 1'b0;
        for (i = 0; i < 300; i++) begin
            #1;
            if (wait_busy === 1'b1 && wait_idle !== 1'b1 && wait_vector !== 1'b1)
                save++;
            if (wait_idle === 1'b1)
                idle_n++;
            if (wait_vector === 1'b1)
                vec++;
            if (wait_done === 1'b1)
                break;
            @(posedge sys_clk);
            if (idle_n == 20)
                irq_pin <= 1'b1;
        end
        check(save, 32'd11);
        check(idle_n > 20, 1'b1);
        check(vec, 32'd2);
        @(posedge sys_clk);
        irq_pin <= 1'b0;
        #1;
        check(wait_busy, 1'b0);
        // Count is complete once the last vector cycle has been counted
        check(wait_total, cpuodw_pkg::WAIT_BASE_CYCLES + idle_n);
        $display("test wait done");
    endtask

    // ************************
    // Main sequence and watchdog
    // ************************
    initial begin
        errors = 0;
        n_tests = 0;
        {reset, op_start, op_page1, irq_pin, req, slow} = 6'h20;
        {op_code, mem_data, mem_target, flags_src} = 32'h0;
        {pc_next, word, count} = 34'h0;
        op_mode = cpuodw_pkg::MODE_INH;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        test_reset();
        test_transfer();
        test_operands();
        test_flags();
        test_wait();
        report_and_stop();
    end
    initial begin
        // Whole run needs about 120 cycles
        #(4000 * 20);
        errors++;
        report_and_stop();
    end
endmodule
